// file: logic/tpio_pkg.sv
// Constants shared by the timer pin I/O mode decode block.
package tpio_pkg;
    // Register offsets on the plain register port.
    localparam logic [3:0] OFF_PIN_CTL_LOW_CH0 = 4'h0;
    localparam logic [3:0] OFF_PIN_CTL_CH1 = 4'h1;
    localparam logic [3:0] OFF_TIMER_MODE_CH0 = 4'h2;
    localparam logic [3:0] OFF_GEN_REG_D_CH0 = 4'h3;
    localparam logic [3:0] OFF_GEN_REG_C_CH0 = 4'h4;
    localparam logic [3:0] OFF_GEN_REG_B_CH1 = 4'h5;
    localparam logic [3:0] OFF_STATUS = 4'h6;
    // Field positions.
    localparam int FLD_HI_LSB = 4;
    localparam int FLD_LO_LSB = 0;
    localparam int BIT_BUF_A = 0;
    localparam int BIT_BUF_B = 1;
    // Reset values.
    localparam logic [7:0] RST_PIN_CTL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [15:0] RST_GEN_REG = 16'h0000;
    // Pin control field codes.
    localparam logic [3:0] CODE_OFF_LO = 4'h0;
    localparam logic [3:0] CODE_OFF_HI = 4'h4;
    localparam logic [3:0] CODE_CAP_RISE = 4'h8;
    localparam logic [3:0] CODE_CAP_FALL = 4'h9;
    // Compare actions held in the low two bits of an output code.
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
endpackage : tpio_pkg

// file: logic/tpio_channel.sv
// One general register with its timer pin, steered by a 4-bit pin control field.
module tpio_channel #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Configuration.
    input wire logic [3:0] pin_ctl,
    input wire logic buffer_mode,
    input wire logic ctl_written,
    // Counter and software access to the general register.
    input wire logic [WIDTH-1:0] counter,
    input wire logic gen_wr,
    input wire logic [WIDTH-1:0] gen_wdata,
    // Synchronised pin level.
    input wire logic pin_in_s,
    // Results.
    output logic [WIDTH-1:0] gen_q,
    output logic pin_out_q,
    output logic pin_oe_n_q,
    output logic capture_q,
    output logic match_q
);
    logic pin_prev_q;
    logic is_capture;
    logic is_output;
    logic rise;
    logic fall;
    logic cap_evt;
    logic cmp_evt;
    logic ctl_written_q;

    // Decode the field; buffer mode disables both functions.
    assign is_capture = !buffer_mode && pin_ctl[3] && !pin_ctl[2];
    assign is_output = !buffer_mode && !pin_ctl[3] && (pin_ctl[1:0] != 2'h0);
    assign rise = pin_in_s && !pin_prev_q;
    assign fall = !pin_in_s && pin_prev_q;

    // Select the capture edge from the field.
    always_comb begin
        cap_evt = 1'b0;
        if (is_capture) begin
            if (pin_ctl == tpio_pkg::CODE_CAP_RISE) begin
                cap_evt = rise;
            end else if (pin_ctl == tpio_pkg::CODE_CAP_FALL) begin
                cap_evt = fall;
            end else begin
                cap_evt = rise || fall;
            end
        end
    end

    assign cmp_evt = is_output && (counter == gen_q);

    // Previous pin level for edge detection; the pin is this channel's own.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_in_s;
        end
    end

    // The field register takes a write at the strobe's own edge, so the initial level
    // is applied one edge later, once the new code is visible here.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl_written_q <= 1'b0;
        end else begin
            ctl_written_q <= ctl_written;
        end
    end

    // General register: software write, or counter latched on capture.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gen_q <= tpio_pkg::RST_GEN_REG;
        end else if (cap_evt) begin
            gen_q <= counter;
        end else if (gen_wr) begin
            gen_q <= gen_wdata;
        end
    end

    // Event pulses for status.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            capture_q <= 1'b0;
            match_q <= 1'b0;
        end else begin
            capture_q <= cap_evt;
            match_q <= cmp_evt;
        end
    end

    // Pin drive: initial level on a field write, then the compare action.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_out_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_oe_n_q <= !is_output;
            if (ctl_written_q || !is_output) begin
                pin_out_q <= pin_ctl[2];
            end else if (cmp_evt) begin
                case (pin_ctl[1:0])
                    tpio_pkg::ACT_LOW: pin_out_q <= 1'b0;
                    tpio_pkg::ACT_HIGH: pin_out_q <= 1'b1;
                    tpio_pkg::ACT_TOGGLE: pin_out_q <= !pin_out_q;
                    default: pin_out_q <= pin_out_q;
                endcase
            end
        end
    end
endmodule : tpio_channel

// file: logic/tpio_top.sv
// Timer pin I/O mode decode: control registers, counter and three pin channels.
//
// Contract
// - Codes 0001 to 0011 drive the pin low as the initial level.
// - Codes 0101 to 0111 drive the pin high as the initial level.
// - Output codes ending 01 drive the pin low on each compare match.
// - Output codes ending 10 drive the pin high on each compare match.
// - Output codes ending 11 invert the pin on each compare match.
// - Code 1000 captures the counter on a rising pin edge.
// - Code 1001 captures the counter on a falling pin edge.
// - Codes 101x capture on both edges and software never writes 11xx.
// - Register D of channel 0 captures from its own pin.
// - Register C of channel 0 captures from its own pin.
// - Register B of channel 1 captures from its own pin.
// - With buffer mode B set, register D does neither capture nor compare.
// - With buffer mode A set, register C does neither capture nor compare.
// - Channel 0 low control holds the D field in bits 7:4 and C in bits 3:0.
// - Channel 1 control holds the B field in bits 7:4.
module tpio_top #(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_q,
    // Timer pins, three signals each.
    input wire logic timer_pin_d_ch0_in,
    output logic timer_pin_d_ch0_out,
    output logic timer_pin_d_ch0_oe_n,
    input wire logic timer_pin_c_ch0_in,
    output logic timer_pin_c_ch0_out,
    output logic timer_pin_c_ch0_oe_n,
    input wire logic timer_pin_b_ch1_in,
    output logic timer_pin_b_ch1_out,
    output logic timer_pin_b_ch1_oe_n
);
    logic [7:0] pin_control_low_ch0_q;
    logic [7:0] pin_control_ch1_q;
    logic [7:0] timer_mode_reg_ch0_q;
    logic [WIDTH-1:0] counter_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic wr_ctl0;
    logic wr_ctl1;
    logic wr_mode;
    logic [WIDTH-1:0] gen_d;
    logic [WIDTH-1:0] gen_c;
    logic [WIDTH-1:0] gen_b;
    logic [2:0] cap_evt;
    logic [2:0] match_evt;
    logic [5:0] status_q;
    logic status_rd;

    // Write decode, and the status read decode.
    assign wr_ctl0 = reg_wr && (reg_addr == tpio_pkg::OFF_PIN_CTL_LOW_CH0);
    assign wr_ctl1 = reg_wr && (reg_addr == tpio_pkg::OFF_PIN_CTL_CH1);
    assign wr_mode = reg_wr && (reg_addr == tpio_pkg::OFF_TIMER_MODE_CH0);
    assign status_rd = reg_rd && (reg_addr == tpio_pkg::OFF_STATUS);

    // Control registers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_control_low_ch0_q <= tpio_pkg::RST_PIN_CTL;
            pin_control_ch1_q <= tpio_pkg::RST_PIN_CTL;
            timer_mode_reg_ch0_q <= tpio_pkg::RST_MODE;
        end else begin
            if (wr_ctl0) begin
                pin_control_low_ch0_q <= reg_wdata[7:0];
            end
            if (wr_ctl1) begin
                pin_control_ch1_q <= reg_wdata[7:0];
            end
            if (wr_mode) begin
                timer_mode_reg_ch0_q <= reg_wdata[7:0];
            end
        end
    end

    // Free running up counter shared by all channels.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            counter_q <= '0;
        end else begin
            counter_q <= counter_q + 1'b1;
        end
    end

    // Two-stage synchronisers for the pin inputs.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {timer_pin_b_ch1_in, timer_pin_c_ch0_in, timer_pin_d_ch0_in};
            sync2_q <= sync1_q;
        end
    end

    // Register D of channel 0, high field of the low control register.
    tpio_channel #(.WIDTH(WIDTH)) u_ch0_d (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_ctl(pin_control_low_ch0_q[tpio_pkg::FLD_HI_LSB +: 4]),
        .buffer_mode(timer_mode_reg_ch0_q[tpio_pkg::BIT_BUF_B]),
        .ctl_written(wr_ctl0),
        .counter(counter_q),
        .gen_wr(reg_wr && (reg_addr == tpio_pkg::OFF_GEN_REG_D_CH0)),
        .gen_wdata(reg_wdata[WIDTH-1:0]),
        .pin_in_s(sync2_q[0]),
        .gen_q(gen_d),
        .pin_out_q(timer_pin_d_ch0_out),
        .pin_oe_n_q(timer_pin_d_ch0_oe_n),
        .capture_q(cap_evt[0]),
        .match_q(match_evt[0])
    );

    // Register C of channel 0, low field of the low control register.
    tpio_channel #(.WIDTH(WIDTH)) u_ch0_c (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_ctl(pin_control_low_ch0_q[tpio_pkg::FLD_LO_LSB +: 4]),
        .buffer_mode(timer_mode_reg_ch0_q[tpio_pkg::BIT_BUF_A]),
        .ctl_written(wr_ctl0),
        .counter(counter_q),
        .gen_wr(reg_wr && (reg_addr == tpio_pkg::OFF_GEN_REG_C_CH0)),
        .gen_wdata(reg_wdata[WIDTH-1:0]),
        .pin_in_s(sync2_q[1]),
        .gen_q(gen_c),
        .pin_out_q(timer_pin_c_ch0_out),
        .pin_oe_n_q(timer_pin_c_ch0_oe_n),
        .capture_q(cap_evt[1]),
        .match_q(match_evt[1])
    );

    // Register B of channel 1, high field of its control register.
    tpio_channel #(.WIDTH(WIDTH)) u_ch1_b (
        .clk_sys(clk_sys),
        .rst(rst),
        .pin_ctl(pin_control_ch1_q[tpio_pkg::FLD_HI_LSB +: 4]),
        .buffer_mode(1'b0),
        .ctl_written(wr_ctl1),
        .counter(counter_q),
        .gen_wr(reg_wr && (reg_addr == tpio_pkg::OFF_GEN_REG_B_CH1)),
        .gen_wdata(reg_wdata[WIDTH-1:0]),
        .pin_in_s(sync2_q[2]),
        .gen_q(gen_b),
        .pin_out_q(timer_pin_b_ch1_out),
        .pin_oe_n_q(timer_pin_b_ch1_oe_n),
        .capture_q(cap_evt[2]),
        .match_q(match_evt[2])
    );

    // Sticky event flags, cleared by reading; a new event wins over the clear.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_q <= 6'h00;
        end else begin
            status_q <= (status_rd ? 6'h00 : status_q) | {match_evt, cap_evt};
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                tpio_pkg::OFF_PIN_CTL_LOW_CH0: reg_rdata_q <= {8'h00, pin_control_low_ch0_q};
                tpio_pkg::OFF_PIN_CTL_CH1: reg_rdata_q <= {8'h00, pin_control_ch1_q};
                tpio_pkg::OFF_TIMER_MODE_CH0: reg_rdata_q <= {8'h00, timer_mode_reg_ch0_q};
                tpio_pkg::OFF_GEN_REG_D_CH0: reg_rdata_q <= 16'(gen_d);
                tpio_pkg::OFF_GEN_REG_C_CH0: reg_rdata_q <= 16'(gen_c);
                tpio_pkg::OFF_GEN_REG_B_CH1: reg_rdata_q <= 16'(gen_b);
                tpio_pkg::OFF_STATUS: reg_rdata_q <= {10'h000, status_q};
                default: reg_rdata_q <= 16'h0000;
            endcase
        end else begin
            reg_rdata_q <= 16'h0000;
        end
    end
endmodule : tpio_top

// file: verification/tpio_pin_model.sv
// Outside world model of the three timer pins.
module tpio_pin_model (
    // Levels the outside source puts on the pins, order D, C, B.
    input wire logic [2:0] ext_lvl,
    // Drive levels and enables of the block.
    input wire logic [2:0] drv,
    input wire logic [2:0] oe_n,
    // Resolved pin levels.
    output logic [2:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // A pin the block drives shows its level, otherwise the outside source wins.
    assign pin = (~oe_n & drv) | (oe_n & ext_lvl);
endmodule : tpio_pin_model

// file: verification/tpio_monitor.sv
// Checker on the ports of the timer pin decode block.
module tpio_monitor (
    // Clock, reset and register port.
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata_q,
    // Pin outputs.
    input wire logic timer_pin_d_ch0_out,
    input wire logic timer_pin_d_ch0_oe_n,
    input wire logic timer_pin_c_ch0_out,
    input wire logic timer_pin_c_ch0_oe_n,
    input wire logic timer_pin_b_ch1_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] buf_q;
    logic [7:0] ctl_q;
    logic wr0;
    logic wr1;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    assign wr0 = reg_wr && reg_addr == tpio_pkg::OFF_PIN_CTL_LOW_CH0;
    assign wr1 = reg_wr && reg_addr == tpio_pkg::OFF_PIN_CTL_CH1;
    // Shadows of the buffer mode bits and the channel 0 control byte.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            buf_q <= 2'h0;
            ctl_q <= 8'h00;
        end else if (reg_wr && reg_addr == tpio_pkg::OFF_TIMER_MODE_CH0) begin
            buf_q <= reg_wdata[1:0];
        end else if (wr0) begin
            ctl_q <= reg_wdata[7:0];
        end
    end
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
        else $error("read data not idle");
    AST_RD_CTL: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata_q == {8'h00, ctl_q})
        else $error("control readback wrong");
    AST_INIT_LO_D: assert property (wr0 && !buf_q[1] && reg_wdata[7:4] inside {[4'h1:4'h3]}
        |-> ##2 !timer_pin_d_ch0_out && !timer_pin_d_ch0_oe_n) else $error("D initial low");
    AST_INIT_HI_C: assert property (wr0 && !buf_q[0] && reg_wdata[3:0] inside {[4'h5:4'h7]}
        |-> ##2 timer_pin_c_ch0_out && !timer_pin_c_ch0_oe_n) else $error("C initial high");
    AST_OFF_B: assert property (wr1 && reg_wdata[5:4] == 2'h0 |-> ##2 timer_pin_b_ch1_oe_n)
        else $error("B pin driven");
    AST_BUF_D: assert property (wr0 && buf_q[1] |=> timer_pin_d_ch0_oe_n [*2])
        else $error("D driven in buffer mode");
    AST_BUF_C: assert property (wr0 && buf_q[0] |=> timer_pin_c_ch0_oe_n [*2])
        else $error("C driven in buffer mode");
    // A write moves the enables one edge after it is taken, so only the previous cycle must be quiet; the check asks for two.
    AST_OE_HOLD: assert property (!reg_wr && !$past(reg_wr) |=> $stable({timer_pin_d_ch0_oe_n,
        timer_pin_c_ch0_oe_n, timer_pin_b_ch1_oe_n})) else $error("enable moved alone");
endmodule : tpio_monitor

bind tpio_top tpio_monitor u_tpio_monitor (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .timer_pin_d_ch0_out(timer_pin_d_ch0_out), .timer_pin_d_ch0_oe_n(timer_pin_d_ch0_oe_n),
    .timer_pin_c_ch0_out(timer_pin_c_ch0_out), .timer_pin_c_ch0_oe_n(timer_pin_c_ch0_oe_n),
    .timer_pin_b_ch1_oe_n(timer_pin_b_ch1_oe_n));

// file: verification/tpio_top_tb.sv
// Self-checking bench of the timer pin decode block.
module tpio_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata_q, rv, t0, cyc;
    logic [15:0] prev [3];
    logic [2:0] ext_lvl = 3'h0;
    logic [2:0] out, oe_n, pin;
    logic [5:0] pv;
    int errors = 0;
    int checked = 0;
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
    assign pv = {out[2], oe_n[2], out[1], oe_n[1], out[0], oe_n[0]};
    tpio_pin_model u_tpio_pin_model (.ext_lvl(ext_lvl), .drv(out), .oe_n(oe_n), .pin(pin));
    tpio_top u_tpio_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .timer_pin_d_ch0_in(pin[2]), .timer_pin_d_ch0_out(out[2]), .timer_pin_d_ch0_oe_n(oe_n[2]),
        .timer_pin_c_ch0_in(pin[1]), .timer_pin_c_ch0_out(out[1]), .timer_pin_c_ch0_oe_n(oe_n[1]),
        .timer_pin_b_ch1_in(pin[0]), .timer_pin_b_ch1_out(out[0]), .timer_pin_b_ch1_oe_n(oe_n[0]));
    // Clock, and a cycle count that follows the free-running counter.
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= rst ? 16'h0000 : cyc + 16'h0001;
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask : rd
    // Aims all three compare registers just ahead of the counter and waits for a match.
    task automatic cmp_round(input logic [15:0] mode, input logic [15:0] ctl,
        input logic [5:0] e, input logic [2:0] em);
        wr(tpio_pkg::OFF_TIMER_MODE_CH0, mode);
        wr(tpio_pkg::OFF_PIN_CTL_LOW_CH0, ctl);
        t0 = cyc + 16'h0028;
        for (int i = 3; i < 6; i++) wr(4'(i), t0);
        rv = 16'h0000;
        for (int n = 0; n < 100 && rv[5:3] == 3'h0; n++) rd(tpio_pkg::OFF_STATUS, rv);
        `CHK("pins after match", e, pv)
        `CHK("match flags", em, rv[5:3])
        rd(tpio_pkg::OFF_STATUS, rv);
        `CHK("status cleared", 16'h0000, rv)
    endtask : cmp_round
    // Moves one pin, then checks which general registers took the counter.
    task automatic cap_step(input int p, input logic v, input logic [2:0] e);
        @(posedge clk_sys);
        ext_lvl[p] <= v;
        t0 = cyc;
        repeat (6) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            rd(4'(3 + i), rv);
            if (e[2 - i]) `CHK("captured", 1'b1, rv - t0 < 16'h0010)
            else `CHK("held", prev[i], rv)
            prev[i] = rv;
        end
    endtask : cap_step
    task automatic report_and_stop;
        $display("Counts: %0d checked, %0d errors", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 0; a < 3; a++) begin
            rd(4'(a), rv);
            `CHK("reset value", 16'h0000, rv)
        end
        rd(4'hF, rv);
        `CHK("unmapped", 16'h0000, rv)
        `CHK("pins at reset", 6'h15, pv)
        $display("Test reset done");
        for (int c = 0; c < 8; c++) begin
            wr(tpio_pkg::OFF_PIN_CTL_LOW_CH0, {8'hFF, 4'(c), 4'(c)});
            wr(tpio_pkg::OFF_PIN_CTL_CH1, {8'h00, 4'(c), 4'h0});
            rd(tpio_pkg::OFF_PIN_CTL_LOW_CH0, rv);
            `CHK("control readback", {8'h00, 4'(c), 4'(c)}, rv)
            `CHK("initial pins", {3{c[2], c[1:0] == 2'h0}}, pv)
        end
        $display("Test initial levels done");
        wr(tpio_pkg::OFF_PIN_CTL_CH1, 16'h0030);
        cmp_round(16'h0001, 16'h0025, 6'h2E, 3'h5);
        cmp_round(16'h0002, 16'h0065, 6'h30, 3'h6);
        $display("Test compare done");
        // Fields first, while D is still buffered, so its pin never drives high and falls back.
        wr(tpio_pkg::OFF_PIN_CTL_LOW_CH0, 16'h009A);
        wr(tpio_pkg::OFF_TIMER_MODE_CH0, 16'h0000);
        wr(tpio_pkg::OFF_PIN_CTL_CH1, 16'h0080);
        for (int i = 0; i < 3; i++) rd(4'(3 + i), prev[i]);
        cap_step(0, 1'b1, 3'b001);
        cap_step(0, 1'b0, 3'b000);
        cap_step(2, 1'b1, 3'b000);
        cap_step(2, 1'b0, 3'b100);
        cap_step(1, 1'b1, 3'b010);
        cap_step(1, 1'b0, 3'b010);
        $display("Test capture done");
        report_and_stop();
    end
    // Watchdog against a hung run.
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        report_and_stop();
    end
endmodule : tpio_top_tb
